/* rtl/pmt_target.sv */
// bus target: filtered sampling, timeouts, stretching, byte stream out
// Function
// - abort and re-arm after clock-low timeout
// - host sends STOP after its own timeout
// - host high time bounded; idle after 50us
// - target stretch total per message limited
// - host byte-segment stretch stays under limit
// - spikes up to 50ns never seen
// - bus clock between 50kHz and 2MHz
// - high-speed mode never entered or acked
module pmt_target
	import pmt_pkg::*;
#(
	parameter int TIMEOUT_CYC = DEV_TMO_CYC,
	parameter int STRETCH_CYC = DEV_STR_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	pmt_bus_if.device bus,
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data
);

	////////////////////////////////////////////////////////////////////////
	// link domain: synchronise and filter
	logic [1:0] s1, s2, flt, prev;
	logic [1:0] next_s1, next_s2, next_flt, next_prev;
	logic [1:0][1:0] fcnt, next_fcnt;

	always_comb begin
		next_s1 = {bus.sda, bus.scl};
		next_s2 = s1;
		next_flt = flt;
		next_fcnt = fcnt;
		next_prev = flt;
		for (int i = 0; i < 2; i++) begin
			if (s2[i] == flt[i]) begin
				next_fcnt[i] = 2'h0;
			end else if (fcnt[i] == FILT_LAST) begin
				next_flt[i] = s2[i];
				next_fcnt[i] = 2'h0;
			end else begin
				next_fcnt[i] = fcnt[i] + 2'h1;
			end
		end
	end

	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1 <= 2'h3;
			s2 <= 2'h3;
			flt <= 2'h3;
			prev <= 2'h3;
			fcnt <= '0;
		end else begin
			s1 <= next_s1;
			s2 <= next_s2;
			flt <= next_flt;
			prev <= next_prev;
			fcnt <= next_fcnt;
		end
	end

	logic scl_f, sda_f, rise, fall, start, stop;
	assign scl_f = flt[0];
	assign sda_f = flt[1];
	assign rise = scl_f & ~prev[0];
	assign fall = ~scl_f & prev[0];
	assign start = scl_f & prev[0] & prev[1] & ~sda_f;
	assign stop = scl_f & prev[0] & ~prev[1] & sda_f;

	////////////////////////////////////////////////////////////////////////
	// link domain: protocol engine
	pmt_dstate_t state, next_state;
	logic [3:0] bitn, next_bitn;
	logic [7:0] shift, next_shift, byte_q, next_byte_q;
	logic [CNT_W-1:0] low_cnt, next_low_cnt, str_cnt, next_str_cnt;
	logic scl_oe_n, next_scl_oe_n, sda_oe_n, next_sda_oe_n;
	logic req_tgl, next_req_tgl, ak1, ak2, busy;
	logic ack_tgl;

	assign busy = req_tgl ^ ak2;

	always_comb begin
		next_state = state;
		next_bitn = bitn;
		next_shift = shift;
		next_byte_q = byte_q;
		next_scl_oe_n = scl_oe_n;
		next_sda_oe_n = sda_oe_n;
		next_req_tgl = req_tgl;
		next_str_cnt = str_cnt;
		next_low_cnt = low_cnt;
		if (rise || stop) begin
			next_low_cnt = '0;
		end else if (!scl_f && low_cnt != '1) begin
			next_low_cnt = low_cnt + 1'b1;
		end
		if (state != D_IDLE && low_cnt >= CNT_W'(TIMEOUT_CYC)) begin
			// release both lines and wait for a fresh START
			next_state = D_IDLE;
			next_scl_oe_n = 1'b1;
			next_sda_oe_n = 1'b1;
		end else if (stop) begin
			next_state = D_IDLE;
			next_scl_oe_n = 1'b1;
			next_sda_oe_n = 1'b1;
		end else if (start) begin
			next_state = D_ADDR;
			next_bitn = 4'h0;
			next_str_cnt = '0;
			next_scl_oe_n = 1'b1;
			next_sda_oe_n = 1'b1;
		end else begin
			unique case (state)
				D_IDLE, D_SKIP: begin
				end
				D_ADDR, D_DATA: begin
					if (rise) begin
						next_shift = {shift[6:0], sda_f};
						next_bitn = bitn + 4'h1;
					end else if (fall && bitn == BYTE_BITS) begin
						next_bitn = 4'h0;
						if (state == D_DATA) begin
							next_state = D_DSTR;
							next_scl_oe_n = 1'b0;
						end else if (shift[7:3] == HS_CODE) begin
							next_state = D_SKIP;
						end else if (shift == {OWN_ADDR, 1'b0}) begin
							next_state = D_AACK;
							next_sda_oe_n = 1'b0;
						end else begin
							next_state = D_SKIP;
						end
					end
				end
				D_AACK, D_DACK: begin
					if (fall) begin
						next_state = D_DATA;
						next_sda_oe_n = 1'b1;
					end
				end
				D_DSTR: begin
					// wait for the user side to take the previous byte
					if (!busy) begin
						next_byte_q = shift;
						next_req_tgl = ~req_tgl;
						next_sda_oe_n = 1'b0;
						next_scl_oe_n = 1'b1;
						next_state = D_DACK;
					end else if (str_cnt >= CNT_W'(STRETCH_CYC)) begin
						// budget spent: give up and leave the byte unacked
						next_scl_oe_n = 1'b1;
						next_state = D_SKIP;
					end else begin
						next_str_cnt = str_cnt + 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= D_IDLE;
			bitn <= 4'h0;
			shift <= 8'h00;
			byte_q <= 8'h00;
			low_cnt <= '0;
			str_cnt <= '0;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			req_tgl <= 1'b0;
			ak1 <= 1'b0;
			ak2 <= 1'b0;
		end else begin
			state <= next_state;
			bitn <= next_bitn;
			shift <= next_shift;
			byte_q <= next_byte_q;
			low_cnt <= next_low_cnt;
			str_cnt <= next_str_cnt;
			scl_oe_n <= next_scl_oe_n;
			sda_oe_n <= next_sda_oe_n;
			req_tgl <= next_req_tgl;
			ak1 <= ack_tgl;
			ak2 <= ak1;
		end
	end

	assign bus.dev_scl_out = 1'b0;
	assign bus.dev_sda_out = 1'b0;
	assign bus.dev_scl_oe_n = scl_oe_n;
	assign bus.dev_sda_oe_n = sda_oe_n;

	////////////////////////////////////////////////////////////////////////
	// user domain: toggle handshake into a two-entry buffer
	// byte_q stays still while a request is open, so it crosses safely
	logic r1, r2, next_ack_tgl, push, pop;
	logic wp, rp, next_wp, next_rp;
	logic [1:0] cnt, next_cnt;
	logic [7:0] mem [2];
	logic [7:0] next_mem [2];

	assign push = (r2 ^ ack_tgl) && (cnt != FIFO_DEPTH);
	assign pop = out_valid && out_ready;
	assign out_valid = (cnt != 2'h0);
	assign out_data = mem[rp];

	always_comb begin
		next_mem = mem;
		next_wp = wp;
		next_rp = rp;
		next_ack_tgl = ack_tgl;
		if (push) begin
			next_mem[wp] = byte_q;
			next_wp = ~wp;
			next_ack_tgl = r2;
		end
		if (pop) begin
			next_rp = ~rp;
		end
		next_cnt = cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			r1 <= 1'b0;
			r2 <= 1'b0;
			ack_tgl <= 1'b0;
			wp <= 1'b0;
			rp <= 1'b0;
			cnt <= 2'h0;
			mem[0] <= 8'h00;
			mem[1] <= 8'h00;
		end else begin
			r1 <= req_tgl;
			r2 <= r1;
			ack_tgl <= next_ack_tgl;
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
			mem <= next_mem;
		end
	end

endmodule : pmt_target

/* rtl/pmt_pkg.sv */
// shared constants and state types for the bus timing supervisor
package pmt_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int LINK_PERIOD_NS = 32;
	localparam int CNT_W = 24;
	localparam int TIMEOUT_MIN_MS = 25;
	localparam int HIGH_MAX_US = 50;
	localparam int SEXT_MAX_MS = 25;
	localparam int REJ_MAX_NS = 50;
	localparam int BUS_MIN_KHZ = 50;
	localparam int BUS_MAX_KHZ = 2000;
	localparam int BUS_KHZ = 400;
	localparam int HALF_NS = 1000000 / (2 * BUS_KHZ);
	// least times round up, longest times round down
	localparam int HALF_CYC = (HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEV_TMO_CYC =
		(TIMEOUT_MIN_MS * 1000000 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
	localparam int DEV_STR_CYC = SEXT_MAX_MS * 1000000 / LINK_PERIOD_NS;
	localparam int HOST_TMO_CYC =
		(TIMEOUT_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOST_IDLE_CYC = HIGH_MAX_US * 1000 / CLK_PERIOD_NS + 1;
	// a spike spanning two samples is still rejected
	localparam int FILT_CYC = REJ_MAX_NS / LINK_PERIOD_NS + 2;
	localparam logic [1:0] FILT_LAST = 2'(FILT_CYC - 1);
	localparam logic [6:0] OWN_ADDR = 7'h40;
	localparam logic [4:0] HS_CODE = 5'h01;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [4:0] ADDR_ACK_BIT = 5'h08;
	localparam logic [4:0] LAST_BIT = 5'h11;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;
	typedef enum logic [2:0] {
		D_IDLE, D_ADDR, D_AACK, D_DATA, D_DSTR, D_DACK, D_SKIP
	} pmt_dstate_t;
	typedef enum logic [2:0] {
		H_IDLE, H_START, H_LOW, H_RISE, H_HIGH, H_STOP0, H_STOP1, H_STOP2
	} pmt_hstate_t;
endpackage : pmt_pkg

/* rtl/pmt_bus_if.sv */
// open-drain two-wire bus joining host and target
interface pmt_bus_if;
	logic host_scl_out;
	logic host_scl_oe_n;
	logic host_sda_out;
	logic host_sda_oe_n;
	logic dev_scl_out;
	logic dev_scl_oe_n;
	logic dev_sda_out;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;
	// pulled up unless some party drives its low output
	assign scl = (host_scl_oe_n | host_scl_out) & (dev_scl_oe_n | dev_scl_out);
	assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);
	modport host (
		output host_scl_out, host_scl_oe_n, host_sda_out, host_sda_oe_n,
		input scl, sda
	);
	modport device (
		output dev_scl_out, dev_scl_oe_n, dev_sda_out, dev_sda_oe_n,
		input scl, sda
	);
endinterface : pmt_bus_if

/* rtl/pmt_host.sv */
// bus host: one write message per user byte, clock made by a divider
module pmt_host
	import pmt_pkg::*;
#(
	parameter int TIMEOUT_CYC = HOST_TMO_CYC,
	parameter int IDLE_CYC = HOST_IDLE_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	pmt_bus_if.host bus,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	output logic done,
	output logic nack,
	output logic timed_out
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0] s1, s2;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1 <= 2'h3;
			s2 <= 2'h3;
		end else begin
			s1 <= {bus.sda, bus.scl};
			s2 <= s1;
		end
	end

	logic scl_s, sda_s;
	assign scl_s = s2[0];
	assign sda_s = s2[1];

	////////////////////////////////////////////////////////////////////////
	// message sequencer
	pmt_hstate_t state, next_state;
	logic [CNT_W-1:0] tcnt, next_tcnt;
	logic [4:0] bitn, next_bitn;
	logic [17:0] shift, next_shift;
	logic scl_oe_n, next_scl_oe_n, sda_oe_n, next_sda_oe_n;
	logic next_done, next_nack, next_timed_out, half;

	// low and high phases are fixed: no extension by the host
	assign half = (tcnt >= CNT_W'(HALF_CYC - 1));
	assign in_ready = (state == H_IDLE) && (tcnt >= CNT_W'(IDLE_CYC));

	always_comb begin
		next_state = state;
		next_tcnt = tcnt + 1'b1;
		next_bitn = bitn;
		next_shift = shift;
		next_scl_oe_n = scl_oe_n;
		next_sda_oe_n = sda_oe_n;
		next_done = 1'b0;
		next_nack = nack;
		next_timed_out = timed_out;
		unique case (state)
			H_IDLE: begin
				// free only after both lines stayed high long enough
				if (!(scl_s && sda_s)) begin
					next_tcnt = '0;
				end else if (tcnt >= CNT_W'(IDLE_CYC)) begin
					next_tcnt = tcnt;
				end
				if (in_valid && in_ready) begin
					next_shift = {OWN_ADDR, 1'b0, 1'b1, in_data, 1'b1};
					next_bitn = 5'h00;
					next_nack = 1'b0;
					next_timed_out = 1'b0;
					next_sda_oe_n = 1'b0;
					next_tcnt = '0;
					next_state = H_START;
				end
			end
			H_START: begin
				if (half) begin
					next_scl_oe_n = 1'b0;
					next_tcnt = '0;
					next_state = H_LOW;
				end
			end
			H_LOW: begin
				next_sda_oe_n = shift[17];
				if (half) begin
					next_scl_oe_n = 1'b1;
					next_tcnt = '0;
					next_state = H_RISE;
				end
			end
			H_RISE: begin
				if (scl_s) begin
					next_tcnt = '0;
					next_state = H_HIGH;
				end else if (tcnt >= CNT_W'(TIMEOUT_CYC)) begin
					next_timed_out = 1'b1;
					next_tcnt = '0;
					next_state = H_STOP0;
				end
			end
			H_HIGH: begin
				if (half) begin
					next_tcnt = '0;
					next_scl_oe_n = 1'b0;
					next_shift = {shift[16:0], 1'b1};
					next_bitn = bitn + 5'h01;
					if ((bitn == ADDR_ACK_BIT || bitn == LAST_BIT) && sda_s) begin
						next_nack = 1'b1;
						next_state = H_STOP0;
					end else if (bitn == LAST_BIT) begin
						next_state = H_STOP0;
					end else begin
						next_state = H_LOW;
					end
				end
			end
			H_STOP0: begin
				next_scl_oe_n = 1'b0;
				next_sda_oe_n = 1'b0;
				if (half) begin
					next_scl_oe_n = 1'b1;
					next_tcnt = '0;
					next_state = H_STOP1;
				end
			end
			H_STOP1: begin
				if (!scl_s) begin
					next_tcnt = '0;
				end else if (half) begin
					next_sda_oe_n = 1'b1;
					next_tcnt = '0;
					next_state = H_STOP2;
				end
			end
			H_STOP2: begin
				if (half) begin
					next_done = 1'b1;
					next_tcnt = '0;
					next_state = H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= H_IDLE;
			tcnt <= '0;
			bitn <= 5'h00;
			shift <= 18'h3ffff;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			done <= 1'b0;
			nack <= 1'b0;
			timed_out <= 1'b0;
		end else begin
			state <= next_state;
			tcnt <= next_tcnt;
			bitn <= next_bitn;
			shift <= next_shift;
			scl_oe_n <= next_scl_oe_n;
			sda_oe_n <= next_sda_oe_n;
			done <= next_done;
			nack <= next_nack;
			timed_out <= next_timed_out;
		end
	end

	assign bus.host_scl_out = 1'b0;
	assign bus.host_sda_out = 1'b0;
	assign bus.host_scl_oe_n = scl_oe_n;
	assign bus.host_sda_oe_n = sda_oe_n;

endmodule : pmt_host

/* testbench/pmt_chk.sv */
// bus timing assertions between host and target
module pmt_chk
	import pmt_pkg::*;
#(
	parameter int TMO = 300,
	parameter int STR = 150,
	parameter int IDLE = 50
) (
	input wire logic clk,
	input wire logic link_clk,
	input wire logic sys_rst,
	input wire logic host_scl_oe_n,
	input wire logic dev_scl_oe_n,
	input wire logic dev_sda_oe_n,
	input wire logic scl,
	input wire logic sda
);
	// bus period bounds in clk cycles
	localparam int MIN_PER = 1000000 / BUS_MAX_KHZ / CLK_PERIOD_NS;
	localparam int MAX_PER = 1000000 / BUS_MIN_KHZ / CLK_PERIOD_NS;
	logic [15:0] lo, dv, hh, hl, pr, fr;
	logic ls, ld, cs, cd, busy;
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge link_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lo <= '0;
			dv <= '0;
			ls <= 1'b1;
			ld <= 1'b1;
		end else begin
			lo <= scl ? '0 : lo + 16'h1;
			// stretch budget restarts at each start
			dv <= (ls & scl & ld & !sda) ? '0 : dv + 16'(!dev_scl_oe_n);
			ls <= scl;
			ld <= sda;
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{hh, hl, pr, fr} <= '0;
			busy <= 1'b0;
			cs <= 1'b1;
			cd <= 1'b1;
		end else begin
			hh <= (!scl || sda != cd) ? '0 : hh + 16'h1;
			hl <= host_scl_oe_n ? '0 : hl + 16'h1;
			pr <= ((scl & !cs) | (cs & scl & cd & !sda)) ? '0 : pr + 16'h1;
			fr <= (scl & sda) ? fr + 16'h1 : '0;
			// sda edge with scl high: fall opens, rise closes
			if (cs && scl && cd != sda)
				busy <= cd;
			cs <= scl;
			cd <= sda;
		end
	end
	////////////////////////////////////////////////////////////////////////
	a_tmo_release: assert property (
		@(posedge link_clk) disable iff (sys_rst)
		lo > TMO + 8 |-> dev_scl_oe_n && dev_sda_oe_n)
		else $error("target kept bus past timeout");
	a_stretch_budget: assert property (
		@(posedge link_clk) disable iff (sys_rst) dv <= STR + 8)
		else $error("target stretch total too long");
	a_ack_filtered: assert property (
		@(posedge link_clk) disable iff (sys_rst)
		$fell(dev_sda_oe_n) && $stable(dev_scl_oe_n)
		|-> !scl && !$past(scl) && !$past(scl, 2))
		else $error("ack on unfiltered clock");
	a_ack_release: assert property (
		@(posedge link_clk) disable iff (sys_rst)
		$fell(scl) && !dev_sda_oe_n
		|-> !dev_sda_oe_n [*3] ##[1:6] dev_sda_oe_n)
		else $error("ack release timing wrong");
	a_host_high: assert property (
		@(posedge clk) disable iff (sys_rst) busy |-> hh <= HALF_CYC + 8)
		else $error("host clock high too long");
	a_host_low: assert property (
		@(posedge clk) disable iff (sys_rst) hl <= HALF_CYC + 4)
		else $error("host clock low too long");
	a_rate_max: assert property (
		@(posedge clk) disable iff (sys_rst)
		busy && $rose(scl) |-> pr >= MIN_PER)
		else $error("bus clock too fast");
	a_rate_min: assert property (
		@(posedge clk) disable iff (sys_rst) busy |-> pr < MAX_PER)
		else $error("bus clock too slow");
	a_idle_start: assert property (
		@(posedge clk) disable iff (sys_rst)
		!busy && cs && cd && scl && !sda |-> fr >= IDLE)
		else $error("start before bus idle");
	c_overrun: cover property (@(posedge link_clk) dv > STR);
	c_ack: cover property (@(posedge link_clk) $fell(dev_sda_oe_n));
	c_message: cover property (@(posedge clk) $fell(busy));
endmodule : pmt_chk

/* testbench/pmbus_target_bus_timing_tb.sv */
// bench: host and target joined, byte stream checked end to end
module pmbus_target_bus_timing_tb import pmt_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, link_clk, sys_rst, out_valid, out_ready, in_valid, in_ready;
	logic done, nack, timed_out;
	logic rdy_on = 1'b1;
	logic [7:0] out_data, in_data;
	int seed = 73;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [7:0] exp_data[$];
	logic [1:0] exp_flags[$];
	////////////////////////////////////////////////////////////////////////
	pmt_bus_if bus ();
	// stretch budget below timeout so overrun gives a nack, not an abort
	localparam int TGT_TMO = 300;
	localparam int TGT_STR = 150;
	localparam int HST_IDLE = 50;
	pmt_target #(.TIMEOUT_CYC(TGT_TMO), .STRETCH_CYC(TGT_STR)) pmt_target_i (
		.clk, .sys_rst, .link_clk, .bus(bus.device), .out_valid,
		.out_ready, .out_data);
	// host timeout left at its long default: it must outlast any stretch
	pmt_host #(.IDLE_CYC(HST_IDLE)) pmt_host_i (
		.clk, .sys_rst, .bus(bus.host), .in_valid, .in_ready, .in_data,
		.done, .nack, .timed_out);
	// checker idle default already matches the host's idle time
	pmt_chk #(.TMO(TGT_TMO), .STR(TGT_STR)) pmt_chk_i (
		.clk, .link_clk, .sys_rst, .host_scl_oe_n(bus.host_scl_oe_n),
		.dev_scl_oe_n(bus.dev_scl_oe_n), .dev_sda_oe_n(bus.dev_sda_oe_n),
		.scl(bus.scl), .sda(bus.sda));
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#3;
		forever #16 link_clk = ~link_clk;
	end
	task automatic fail_at(input logic [7:0] got, exp);
		num_errors++;
		$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
	endtask : fail_at
	task automatic chk_byte(input logic [7:0] got, exp);
		n_tests++;
		if (got !== exp) fail_at(got, exp);
	endtask : chk_byte
	task automatic chk_flags(input logic [1:0] got, exp);
		n_tests++;
		if (got !== exp) fail_at(8'(got), 8'(exp));
	endtask : chk_flags
	task automatic close_out;
		if (num_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	// a dropped byte is noted only as a nack
	task automatic send(input logic [7:0] b, input logic nk);
		@(posedge clk) #1;
		in_data = b;
		in_valid = 1'b1;
		while (in_ready !== 1'b1) @(posedge clk) #1;
		@(posedge clk) #1;
		in_valid = 1'b0;
		if (!nk) exp_data.push_back(b);
		exp_flags.push_back({nk, 1'b0});
	endtask : send
	task automatic drain;
		while (exp_flags.size() != 0 || exp_data.size() != 0)
			@(posedge clk);
	endtask : drain
	////////////////////////////////////////////////////////////////////////
	// receiver stalls at random, or fully while rdy_on is low
	always @(posedge clk) begin
		#1;
		out_ready = rdy_on && $random(seed) % 3 != 0;
	end
	always @(posedge clk) begin
		if (!sys_rst && out_valid === 1'b1 && out_ready === 1'b1)
			chk_byte(out_data, exp_data.pop_front());
		if (!sys_rst && done === 1'b1)
			chk_flags({nack, timed_out}, exp_flags.pop_front());
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			num_errors++;
			close_out;
		end
	end
	initial begin
		in_valid = 1'b0;
		in_data = 8'h00;
		sys_rst = 1'b1;
		repeat (6) @(posedge clk);
		#1 sys_rst = 1'b0;
		send(8'h00, 1'b0);
		send(8'hff, 1'b0);
		repeat (4) send(8'($random(seed)), 1'b0);
		drain();
		// two bytes fill the buffer, the third waits in the crossing
		// register, the fourth overruns the stretch budget
		rdy_on = 1'b0;
		send(8'ha5, 1'b0);
		send(8'h5a, 1'b0);
		send(8'hc3, 1'b0);
		send(8'h96, 1'b1);
		while (exp_flags.size() != 0) @(posedge clk);
		rdy_on = 1'b1;
		// target must accept a fresh message after the drop
		send(8'h3c, 1'b0);
		drain();
		close_out;
	end
endmodule : pmbus_target_bus_timing_tb
